// >>> core/vfx_map.vh
`ifndef VFX_MAP_VH
`define VFX_MAP_VH
// APB byte offsets
`define VFX_OFF_CSR      12'h000
`define VFX_OFF_IRQ_STS  12'h004
`define VFX_OFF_IRQ_MSK  12'h008
`define VFX_OFF_LAST     12'h00C
// Control/status field positions: flags [5:0], masks [12:7], modes
`define VFX_FLAG_LSB     0
`define VFX_MASK_LSB     7
`define VFX_DAZ_BIT      6
`define VFX_FTZ_BIT      15
// Condition bit order inside a six-bit group
`define VFX_C_INV        0
`define VFX_C_DEN        1
`define VFX_C_DIVZ       2
`define VFX_C_OVF        3
`define VFX_C_UNF        4
`define VFX_C_PREC       5
// Writable bits of the control/status word, and its reset value
`define VFX_CSR_WMASK    32'h0000FFFF
`define VFX_CSR_RST      32'h00001F80
// Fault vector number
`define VFX_FAULT_VEC    8'h13
// Sticky event bits in the interrupt status register
`define VFX_EV_FAULT     0
`define VFX_EV_MASKED    1
`endif

// >>> core/vfx_lane_or.v
`timescale 1ns/10ps
// Reduces per-lane condition bits to one set of flags
module vfx_lane_or #(
  parameter LANES = 4
) (
  input  wire [6*LANES-1:0] lane_cond_i,   // Six condition bits per lane
  input  wire [LANES-1:0]   lane_act_i,    // Lane carries a real sub-operation
  output reg  [5:0]         cond_o         // OR across active lanes
);
  integer k;

  // Lane identity is deliberately dropped; only the union survives
  always @* begin
    cond_o = 6'h00;
    for (k = 0; k < LANES; k = k + 1) begin
      if (lane_act_i[k]) begin
        cond_o = cond_o | lane_cond_i[6*k +: 6];
      end
    end
  end
endmodule

// >>> core/vfx_exc_unit.v
// Notes on behaviour
// - Masked raised condition delivers the default result, no trap.
// - Masked condition: no outward signal, sticky flag set.
// - Unmasked raised condition raises the fault on vector 19, no result.
// - An already-set flag never faults; only fresh conditions do.
// - Faults are precise, taken on the excepting instruction itself.
// - No synchronisation step needed; reporting is immediate.
// - Unmasked overflow, underflow, inexact: computed result withheld.
// - Packed flags are the OR over lanes, lane not recorded.
// - Full IEEE 754 behaviour unless flush or denormal-zero mode.
// - Six conditions, each with its own mask bit.
// - Fault entry through interrupt gate clears interrupt-enable flag.
// - Invalid, divide, denormal pre-compute faults; rest post-compute traps.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "vfx_map.vh"

module vfx_exc_unit #(
  parameter LANES = 4,
  parameter RW    = 64
) (
  input  wire               mclk_i,         // Core clock, 50 MHz
  input  wire               resetn_i,       // Async reset, active low
  // APB slave
  input  wire               psel_i,         // Slave select
  input  wire               penable_i,      // Access phase
  input  wire               pwrite_i,       // Write direction
  input  wire [11:0]        paddr_i,        // Byte address
  input  wire [31:0]        pwdata_i,       // Write data
  input  wire [3:0]         pstrb_i,        // Byte strobes
  output wire               pready_o,       // Always ready
  output reg  [31:0]        prdata_o,       // Read data
  output wire               pslverr_o,      // Unmapped address
  // Execution pipe
  input  wire               op_valid_i,     // One instruction completes this cycle
  input  wire               op_packed_i,    // Packed operation
  input  wire [LANES-1:0]   op_lane_act_i,  // Active lanes
  input  wire [6*LANES-1:0] pre_cond_i,     // Pre-compute conditions per lane
  input  wire [6*LANES-1:0] post_cond_i,    // Post-compute conditions per lane
  input  wire [RW-1:0]      op_result_i,    // Computed or default result
  input  wire               gate_is_intr_i, // Vector 19 gate is an interrupt gate
  output wire               daz_o,          // Denormal inputs as zero
  output wire               ftz_o,          // Flush tiny results to zero
  output wire               ieee_strict_o,  // Neither mode on
  output reg                wb_en_o,        // Write result to destination
  output reg  [RW-1:0]      wb_data_o,      // Result written
  output reg                fault_o,        // Fault pulse, precise
  output reg  [7:0]         fault_vec_o,    // Vector number with fault
  output reg                if_clear_o,     // Clear interrupt-enable flag
  output reg  [5:0]         fault_cond_o,   // Unmasked fresh conditions
  output wire               irq_o           // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Lane reduction

  wire [5:0] pre_or;
  wire [5:0] post_or;
  wire [LANES-1:0] act;

  // Scalar ops use lane 0 only
  assign act = op_packed_i ? op_lane_act_i : {{(LANES-1){1'b0}}, 1'b1};

  vfx_lane_or #(.LANES(LANES)) u_pre (
    .lane_cond_i (pre_cond_i),
    .lane_act_i  (act),
    .cond_o      (pre_or)
  );

  vfx_lane_or #(.LANES(LANES)) u_post (
    .lane_cond_i (post_cond_i),
    .lane_act_i  (act),
    .cond_o      (post_or)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Condition classification

  reg  [31:0] csr_q;
  wire [5:0]  msk = csr_q[`VFX_MASK_LSB +: 6];
  wire [5:0]  pre_cls;
  wire [5:0]  post_cls;
  wire [5:0]  pre_unm;
  wire        pre_fault;
  wire [5:0]  raised;
  wire [5:0]  unm;
  wire        do_fault;

  // Only invalid, denormal, divide count before the arithmetic
  assign pre_cls = pre_or & 6'h07;
  // Overflow, underflow, inexact only after it
  assign post_cls = post_or & 6'h38;
  assign pre_unm = pre_cls & ~msk;
  assign pre_fault = |pre_unm;
  // A pre-compute fault stops the arithmetic, so no post conditions arise
  assign raised = op_valid_i ? (pre_fault ? pre_cls : (pre_cls | post_cls)) : 6'h00;
  // Only conditions raised by this instruction are looked at, never stored flags
  assign unm = raised & ~msk;
  assign do_fault = |unm;

  assign daz_o = csr_q[`VFX_DAZ_BIT];
  assign ftz_o = csr_q[`VFX_FTZ_BIT];
  // Core arithmetic keeps IEEE behaviour while this is high
  assign ieee_strict_o = ~daz_o & ~ftz_o;

  ////////////////////////////////////////////////////////////////////////////
  // Result and fault delivery, registered one cycle after the instruction retires

  // Registered so fault and writeback line up with the instruction's slot
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_en_o      <= 1'b0;
      wb_data_o    <= {RW{1'b0}};
      fault_o      <= 1'b0;
      fault_vec_o  <= 8'h00;
      if_clear_o   <= 1'b0;
      fault_cond_o <= 6'h00;
    end else begin
      // Masked or clean: op_result_i, default or computed, is written back
      wb_en_o <= op_valid_i & ~do_fault;
      if (op_valid_i & ~do_fault) begin
        wb_data_o <= op_result_i;
      end
      // Fault raised for this instruction, never held over
      fault_o      <= do_fault;
      fault_vec_o  <= do_fault ? `VFX_FAULT_VEC : 8'h00;
      if_clear_o   <= do_fault & gate_is_intr_i;
      fault_cond_o <= unm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire       acc  = psel_i & penable_i;
  wire       wr   = acc & pwrite_i;
  wire       rd   = acc & ~pwrite_i;
  wire       hit_csr = (paddr_i == `VFX_OFF_CSR);
  wire       hit_sts = (paddr_i == `VFX_OFF_IRQ_STS);
  wire       hit_msk = (paddr_i == `VFX_OFF_IRQ_MSK);
  wire       hit_lst = (paddr_i == `VFX_OFF_LAST);
  wire       mapped  = hit_csr | hit_sts | hit_msk | hit_lst;
  wire [31:0] bmask  = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}},
                        {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  // Zero wait states keeps the pipe free of bus stalls
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Control/status word

  reg [31:0] csr_d;

  // Hardware only sets flags; a software write may clear them
  always @* begin
    csr_d = csr_q;
    if (wr & hit_csr) begin
      csr_d = (csr_q & ~(bmask & `VFX_CSR_WMASK)) |
              (pwdata_i & bmask & `VFX_CSR_WMASK);
    end
    // Set wins over a same-cycle clear; masked and unmasked both flag
    csr_d[`VFX_FLAG_LSB +: 6] = csr_d[`VFX_FLAG_LSB +: 6] | raised;
  end

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      csr_q <= `VFX_CSR_RST;
    end else begin
      csr_q <= csr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and last-fault capture

  reg  [1:0] sts_q;
  reg  [1:0] imsk_q;
  reg  [5:0] last_q;
  wire [1:0] ev;

  // Masked conditions raise no event on their own
  assign ev[`VFX_EV_FAULT]  = do_fault;
  assign ev[`VFX_EV_MASKED] = 1'b0;

  // Read clears only the bits it reported, so an event after setup survives
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sts_q  <= 2'h0;
      imsk_q <= 2'h0;
      last_q <= 6'h00;
    end else begin
      sts_q <= ((rd & hit_sts) ? (sts_q & ~prdata_o[1:0]) : sts_q) | ev;
      if (wr & hit_msk & pstrb_i[0]) begin
        imsk_q <= pwdata_i[1:0];
      end
      if (do_fault) begin
        last_q <= unm;
      end
    end
  end

  assign irq_o = |(sts_q & imsk_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered in the setup cycle so it stands at the access edge
  // with zero wait states; the snapshot is one cycle older than the access

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      if (hit_csr) begin
        prdata_o <= csr_q;
      end else if (hit_sts) begin
        prdata_o <= {30'h00000000, sts_q};
      end else if (hit_msk) begin
        prdata_o <= {30'h00000000, imsk_q};
      end else if (hit_lst) begin
        prdata_o <= {26'h0000000, last_q};
      end else begin
        prdata_o <= 32'h00000000;
      end
    end
  end

endmodule

// >>> sim/vfx_exc_checker.sv
`timescale 1ns/10ps
module vfx_exc_checker #(
  parameter LANES = 4
) (
  input wire logic               mclk_i,         // Clock
  input wire logic               resetn_i,       // Reset
  input wire logic               psel_i,         // Select
  input wire logic               penable_i,      // Access
  input wire logic               pwrite_i,       // Write
  input wire logic [11:0]        paddr_i,        // Address
  input wire logic [31:0]        pwdata_i,       // Data
  input wire logic               pslverr_o,      // Error
  input wire logic               op_valid_i,     // Retire
  input wire logic               op_packed_i,    // Packed
  input wire logic [LANES-1:0]   op_lane_act_i,  // Lanes
  input wire logic [6*LANES-1:0] pre_cond_i,     // Pre
  input wire logic [6*LANES-1:0] post_cond_i,    // Post
  input wire logic               gate_is_intr_i, // Gate
  input wire logic               wb_en_o,        // Write back
  input wire logic               fault_o,        // Fault
  input wire logic [7:0]         fault_vec_o,    // Vector
  input wire logic               if_clear_o,     // IF clear
  input wire logic [5:0]         fault_cond_o    // Causes
);
  logic [5:0] pr, po, rz, msk_q, exp_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Raised set per op; masks tracked from every write to offset 0, strobes not seen
  always_comb begin
    pr = '0;
    po = '0;
    for (int k = 0; k < LANES; k++)
      if (op_packed_i ? op_lane_act_i[k] : k == 0) begin
        pr = pr | pre_cond_i[6*k +: 6];
        po = po | post_cond_i[6*k +: 6];
      end
    rz = (|(pr & 6'h07 & ~msk_q)) ? pr & 6'h07 : (pr & 6'h07) | (po & 6'h38);
  end
  // Mirror of the mask field and of the expected fault causes
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i) begin
      msk_q <= 6'h3F;
      exp_q <= 6'h00;
    end else begin
      exp_q <= rz & ~msk_q;
      if (psel_i && penable_i && pwrite_i && paddr_i == 12'h000)
        msk_q <= pwdata_i[12:7];
    end
  sequence s_unm;
    op_valid_i && |(rz & ~msk_q);
  endsequence
  sequence s_clean;
    op_valid_i && !(|(rz & ~msk_q));
  endsequence
  fault_take_a: assert property (s_unm |=> fault_o && !wb_en_o && fault_cond_o == exp_q)
    else $error("fault missing or wrong causes");
  masked_res_a: assert property (s_clean |=> wb_en_o && !fault_o)
    else $error("masked op did not deliver");
  idle_quiet_a: assert property (!op_valid_i |=> !fault_o && !wb_en_o)
    else $error("output without an op");
  fault_vec_a: assert property (fault_o |-> fault_vec_o == 8'h13)
    else $error("wrong fault vector");
  vec_zero_a: assert property (!fault_o |-> fault_vec_o == 8'h00)
    else $error("vector without fault");
  gate_clear_a: assert property (s_unm ##1 fault_o |->
    if_clear_o == $past(gate_is_intr_i))
    else $error("interrupt flag clear wrong");
  pre_first_a: assert property (op_valid_i && |(pr & 6'h07 & ~msk_q) |=>
    !(|fault_cond_o[5:3]))
    else $error("post causes with pre fault");
  // Only the four word offsets are mapped; anything else, unaligned too, errs
  apb_err_a: assert property (psel_i && penable_i |->
    pslverr_o == !(paddr_i inside {12'h000, 12'h004, 12'h008, 12'h00C}))
    else $error("slave error wrong");
endmodule

bind vfx_exc_unit vfx_exc_checker #(.LANES(LANES)) i_vfx_exc_checker (.mclk_i, .resetn_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o, .op_valid_i, .op_packed_i,
  .op_lane_act_i, .pre_cond_i, .post_cond_i, .gate_is_intr_i, .wb_en_o, .fault_o, .fault_vec_o,
  .if_clear_o, .fault_cond_o);

// >>> sim/vfx_handler_model.sv
`timescale 1ns/10ps
// Kernel handler stand-in: only a vector 19 entry counts as a call
module vfx_handler_model (
  input  wire logic       mclk_i,   // Clock
  input  wire logic       fault_i,  // Fault pulse
  input  wire logic [7:0] vec_i,    // Vector
  output logic      [7:0] entries_o // Entries
);
  initial entries_o = 8'h00;
  // A fault with any other vector is lost, as with a missing table entry
  always @(posedge mclk_i)
    if (fault_i === 1'h1 && vec_i === 8'h13)
      entries_o <= entries_o + 8'h01;
endmodule

// >>> sim/vfx_exc_unit_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h not %h", $time, a, b); end end
module vfx_exc_unit_tb;
  logic        mclk_i = 1'h0, resetn_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
  logic        pwrite_i = 1'h0, op_valid_i = 1'h0, op_packed_i = 1'h0, gate_is_intr_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [3:0]  pstrb_i = 4'hF, op_lane_act_i = 4'h0;
  logic [23:0] pre_cond_i = 24'h0, post_cond_i = 24'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [63:0] op_result_i = 64'h0, wb_data_o;
  logic [7:0]  fault_vec_o, entries, lfsr = 8'h49;
  logic [5:0]  fault_cond_o, flags = 6'h00, msk = 6'h3F, pr, po, rz;
  logic        pready_o, pslverr_o, daz_o, ftz_o, ieee_strict_o, wb_en_o, fault_o, if_clear_o;
  logic        irq_o, err;
  logic [71:0] notes[$], note;
  int          mismatches = 0, checks_done = 0, faults = 0;
  vfx_exc_unit i_vfx_exc_unit (.mclk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .op_valid_i, .op_packed_i,
    .op_lane_act_i, .pre_cond_i, .post_cond_i, .op_result_i, .gate_is_intr_i, .daz_o, .ftz_o,
    .ieee_strict_o, .wb_en_o, .wb_data_o, .fault_o, .fault_vec_o, .if_clear_o, .fault_cond_o,
    .irq_o);
  vfx_handler_model i_vfx_handler_model (.mclk_i, .fault_i(fault_o), .vec_i(fault_vec_o),
    .entries_o(entries));
  initial forever #10 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Read data and error are taken at the edge that sees pready high; the
  // half cycle wait after it lets register effects settle for later checks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'h1;
    do @(posedge mclk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
    @(negedge mclk_i);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Issue one op and note its expected answer: fault, write-back, causes, data
  task automatic op(input logic pk, input logic [3:0] act, input logic [23:0] pe, pp);
    lfsr = nxt(lfsr);
    @(posedge mclk_i);
    {op_valid_i, op_packed_i, op_lane_act_i, pre_cond_i, post_cond_i} <= {1'h1, pk, act, pe, pp};
    op_result_i <= {8{lfsr}};
    gate_is_intr_i <= lfsr[0];
    pr = 6'h00;
    po = 6'h00;
    // A scalar op uses lane 0 whatever the lane enables say
    for (int k = 0; k < 4; k++)
      if (pk ? act[k] : k == 0) begin
        pr = pr | (pe[6*k +: 6] & 6'h07);
        po = po | (pp[6*k +: 6] & 6'h38);
      end
    rz = (|(pr & ~msk)) ? pr : pr | po;
    flags = flags | rz;
    faults += |(rz & ~msk);
    notes.push_back({|(rz & ~msk), !(|(rz & ~msk)), rz & ~msk,
                     (|(rz & ~msk)) ? 64'h0 : {8{lfsr}}});
    @(posedge mclk_i);
    op_valid_i <= 1'h0;
  endtask
  // Results are compared in order against the oldest note
  always @(negedge mclk_i)
    if (wb_en_o === 1'h1 || fault_o === 1'h1) begin
      note = notes.pop_front();
      `CHK({fault_o, wb_en_o, fault_cond_o, wb_en_o ? wb_data_o : 64'h0}, note)
    end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'h1;
    rd_chk(12'h000, 32'h00001F80);
    for (int i = 0; i < 12; i++)
      op(lfsr[7], lfsr[3:0], {3{lfsr}}, {3{~lfsr}});
    rd_chk(12'h000, 32'h00001F80 | {26'h0, flags});
    $display("masked ops done");
    apb(1'h1, 12'h000, {26'h0, flags});
    msk = 6'h00;
    op(1'h0, 4'h1, 24'h0, 24'h0);
    op(1'h0, 4'hE, 24'hFFFFC0, 24'hFFFFC0);
    for (int c = 0; c < 6; c++)
      op(1'h1, 4'h8, {24{c < 3}} & 24'h1 << 18 + c, {24{c > 2}} & 24'h1 << 18 + c);
    op(1'h1, 4'h1, 24'h000001, 24'h000038);
    rd_chk(12'h000, {26'h0, flags});
    apb(1'h1, 12'h000, 32'h0);
    rd_chk(12'h000, 32'h0);
    $display("unmasked ops done");
    `CHK(irq_o, 1'h0)
    apb(1'h1, 12'h008, 32'h1);
    `CHK(irq_o, 1'h1)
    rd_chk(12'h004, 32'h1);
    `CHK(err, 1'h0)
    `CHK(irq_o, 1'h0)
    rd_chk(12'h010, 32'h0);
    `CHK(err, 1'h1)
    apb(1'h1, 12'h000, 32'h00008040);
    `CHK({daz_o, ftz_o, ieee_strict_o}, 3'h6)
    apb(1'h1, 12'h000, 32'h0);
    `CHK(ieee_strict_o, 1'h1)
    `CHK(entries, faults[7:0])
    `CHK(notes.size(), 0)
    $display("interrupt and modes done");
    stop_test;
  end
  // Watchdog well beyond the hundred or fewer cycles the tests need
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
endmodule
